/* File: src/eac_pkg.sv */
// Shared constants and types for the encoder calibration-status link
package eac_pkg;

  // ==========================================================================
  // Clock and time base
  // ==========================================================================
  localparam int CLK_HZ = 20000000;
  localparam int MS_PER_S = 1000;
  // Cycles in one millisecond tick
  localparam int MS_TICK_CYCLES = CLK_HZ / MS_PER_S;
  localparam int TICK_W = 16;
  localparam int MS_W = 13;

  // ==========================================================================
  // Device timing
  // ==========================================================================
  localparam int POR_INVALID_MS = 500;
  localparam int BLINK_PERIOD_MS = 500;
  localparam int BLINK_HALF_MS = BLINK_PERIOD_MS / 2;

  // ==========================================================================
  // Controller timing
  // ==========================================================================
  localparam int JUDGE_WAIT_S = 5;
  localparam int JUDGE_WAIT_MS = JUDGE_WAIT_S * MS_PER_S;
  localparam int JUDGE_WINDOW_MS = 2 * BLINK_PERIOD_MS;
  localparam int POWER_OFF_MS = 10;
  localparam int POS_W = 16;
  localparam int RETRY_W = 4;

  // ==========================================================================
  // Three-level calibration-request pin
  // ==========================================================================
  typedef enum logic [1:0] {
    CAL_LOW  = 2'h0,
    CAL_MID  = 2'h1,
    CAL_HIGH = 2'h2
  } eac_cal_level_t;

  // Device operating states
  typedef enum logic [1:0] {
    ST_START  = 2'h0,
    ST_NORMAL = 2'h1,
    ST_TUNING = 2'h2,
    ST_DONE   = 2'h3
  } eac_dev_state_t;

  // Controller states
  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_OFF   = 3'h1,
    H_WAIT  = 3'h2,
    H_JUDGE = 3'h3,
    H_RUN   = 3'h4
  } eac_host_state_t;

endpackage : eac_pkg

/* File: src/eac_link_if.sv */
// Pin bundle between the encoder and the motor controller
interface eac_link_if;
  import eac_pkg::*;

  // ==========================================================================
  // Encoder to controller
  // ==========================================================================
  logic a_p;
  logic a_n;
  logic b_p;
  logic b_n;
  logic i_p;
  logic i_n;
  logic tune_progress_waveform;
  logic emitter_fault_waveform;

  // ==========================================================================
  // Controller to encoder
  // ==========================================================================
  eac_cal_level_t cal_level;

  modport device (
    output a_p, a_n, b_p, b_n, i_p, i_n,
    output tune_progress_waveform, emitter_fault_waveform,
    input cal_level
  );

  modport host (
    input a_p, a_n, b_p, b_n, i_p, i_n,
    input tune_progress_waveform, emitter_fault_waveform,
    output cal_level
  );
endinterface : eac_link_if

/* File: src/eac_device.sv */
// Encoder side: power-up validity, calibration mode and status outputs
module eac_device #(
  parameter int TICK_CYCLES = eac_pkg::MS_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  eac_link_if.device link,
  input wire logic step_raw,
  input wire logic dir_raw,
  input wire logic index_raw,
  input wire logic off_scale_raw,
  input wire logic led_high_raw,
  input wire logic tune_done,
  output logic outputs_valid,
  output eac_pkg::eac_dev_state_t dev_state
);
  import eac_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  logic step_s;
  logic dir_s;
  logic index_s;
  logic off_scale_s;
  logic led_high_s;
  eac_cal_level_t cal_s;
  logic step_prev_q;
  logic step_edge;

  // Two flops per asynchronous input, no reset needed
  always_ff @(posedge clock) begin
    sync1_q <= {link.cal_level, led_high_raw, off_scale_raw, index_raw, dir_raw, step_raw};
    sync2_q <= sync1_q;
  end

  assign step_s = sync2_q[0];
  assign dir_s = sync2_q[1];
  assign index_s = sync2_q[2];
  assign off_scale_s = sync2_q[3];
  assign led_high_s = sync2_q[4];
  assign cal_s = eac_cal_level_t'(sync2_q[6:5]);

  // Rising edge of the synchronised step strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      step_prev_q <= 1'b0;
    end else begin
      step_prev_q <= step_s;
    end
  end

  assign step_edge = step_s & ~step_prev_q;

  // ==========================================================================
  // Millisecond time base
  // ==========================================================================
  logic [TICK_W-1:0] tick_cnt_q;
  logic ms_tick;

  assign ms_tick = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));

  // Divider producing a one-cycle enable each millisecond
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
    end else if (ms_tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TICK_W'(1);
    end
  end

  // ==========================================================================
  // Blink generator, 500 ms period
  // ==========================================================================
  logic [MS_W-1:0] blink_ms_q;
  logic blink_q;

  // Toggle every half period
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      blink_ms_q <= '0;
      blink_q <= 1'b0;
    end else if (ms_tick) begin
      if (blink_ms_q == MS_W'(BLINK_HALF_MS - 1)) begin
        blink_ms_q <= '0;
        blink_q <= ~blink_q;
      end else begin
        blink_ms_q <= blink_ms_q + MS_W'(1);
      end
    end
  end

  // ==========================================================================
  // Quadrature generator
  // ==========================================================================
  logic [1:0] phase_q;
  logic quad_a;
  logic quad_b;

  // Forward steps raise A first, reverse steps raise B first
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase_q <= 2'h0;
    end else if (step_edge) begin
      if (dir_s) begin
        phase_q <= phase_q + 2'h1;
      end else begin
        phase_q <= phase_q - 2'h1;
      end
    end
  end

  // Gray sequence 00, 10, 11, 01 on A and B
  assign quad_a = (phase_q == 2'h1) | (phase_q == 2'h2);
  assign quad_b = phase_q[1];

  // ==========================================================================
  // Power-up validity window
  // ==========================================================================
  logic [MS_W-1:0] por_ms_q;
  logic valid_q;

  // Valid once A/B toggles or the invalid time runs out
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      por_ms_q <= '0;
      valid_q <= 1'b0;
    end else if (!valid_q) begin
      if (step_edge) begin
        valid_q <= 1'b1;
      end else if (ms_tick) begin
        if (por_ms_q == MS_W'(POR_INVALID_MS - 1)) begin
          valid_q <= 1'b1;
        end
        por_ms_q <= por_ms_q + MS_W'(1);
      end
    end
  end

  // ==========================================================================
  // Mode state machine
  // ==========================================================================
  eac_dev_state_t state_q;
  logic armed_q;

  // Request level is taken once, then only off-scale or done move it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= ST_START;
    end else begin
      case (state_q)
        ST_START: begin
          if (cal_s != CAL_LOW) begin
            state_q <= ST_TUNING;
          end else begin
            state_q <= ST_NORMAL;
          end
        end
        ST_NORMAL: begin
          if (armed_q && !off_scale_s && !step_edge) begin
            state_q <= ST_TUNING;
          end
        end
        ST_TUNING: begin
          if (tune_done) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_q <= ST_DONE;
        end
        default: begin
          state_q <= ST_START;
        end
      endcase
    end
  end

  // Off-scale seen during normal operation arms the return trigger
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
    end else if (state_q != ST_NORMAL) begin
      armed_q <= 1'b0;
    end else if (off_scale_s) begin
      armed_q <= 1'b1;
    end else if (!step_edge) begin
      armed_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Position outputs
  // ==========================================================================
  logic drive_en;
  logic a_p_q;
  logic a_n_q;
  logic b_p_q;
  logic b_n_q;
  logic i_p_q;
  logic i_n_q;

  assign drive_en = valid_q && (state_q == ST_NORMAL);

  // All pairs held low while invalid or not in normal operation
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      a_p_q <= 1'b0;
      a_n_q <= 1'b0;
      b_p_q <= 1'b0;
      b_n_q <= 1'b0;
      i_p_q <= 1'b0;
      i_n_q <= 1'b0;
    end else begin
      a_p_q <= drive_en & quad_a;
      a_n_q <= drive_en & ~quad_a;
      b_p_q <= drive_en & quad_b;
      b_n_q <= drive_en & ~quad_b;
      i_p_q <= drive_en & index_s;
      i_n_q <= drive_en & ~index_s;
    end
  end

  // ==========================================================================
  // Status outputs
  // ==========================================================================
  logic progress_q;
  logic fault_q;

  // Misalignment outranks current warning, which outranks progress
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      progress_q <= 1'b0;
      fault_q <= 1'b0;
    end else if (off_scale_s) begin
      progress_q <= 1'b0;
      fault_q <= 1'b1;
    end else if (led_high_s) begin
      progress_q <= 1'b0;
      fault_q <= blink_q;
    end else begin
      fault_q <= 1'b0;
      case (state_q)
        ST_TUNING: progress_q <= blink_q;
        ST_DONE: progress_q <= 1'b1;
        default: progress_q <= 1'b0;
      endcase
    end
  end

  assign link.a_p = a_p_q;
  assign link.a_n = a_n_q;
  assign link.b_p = b_p_q;
  assign link.b_n = b_n_q;
  assign link.i_p = i_p_q;
  assign link.i_n = i_n_q;
  assign link.tune_progress_waveform = progress_q;
  assign link.emitter_fault_waveform = fault_q;
  assign outputs_valid = valid_q;
  assign dev_state = state_q;

endmodule // eac_device

/* File: src/eac_host.sv */
// Motor controller side: power sequencing, calibration judging, position count
module eac_host #(
  parameter int TICK_CYCLES = eac_pkg::MS_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  eac_link_if.host link,
  input wire logic tune_request,
  output logic power_en,
  output logic run_active,
  output logic tune_ok,
  output logic [eac_pkg::RETRY_W-1:0] tune_retries,
  output logic [eac_pkg::POS_W-1:0] position
);
  import eac_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic a_s;
  logic b_s;
  logic prog_s;

  // Two flops each on the A, B and progress encoder outputs
  always_ff @(posedge clock) begin
    sync1_q <= {link.tune_progress_waveform, link.b_p, link.a_p};
    sync2_q <= sync1_q;
  end

  assign a_s = sync2_q[0];
  assign b_s = sync2_q[1];
  assign prog_s = sync2_q[2];

  // ==========================================================================
  // Millisecond time base
  // ==========================================================================
  logic [TICK_W-1:0] tick_cnt_q;
  logic ms_tick;

  assign ms_tick = (tick_cnt_q == TICK_W'(TICK_CYCLES - 1));

  // One-cycle enable each millisecond
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tick_cnt_q <= '0;
    end else if (ms_tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TICK_W'(1);
    end
  end

  // ==========================================================================
  // Power and calibration sequencer
  // ==========================================================================
  eac_host_state_t state_q;
  logic [MS_W-1:0] ms_q;
  logic req_q;
  logic req_prev_q;
  logic low_seen_q;
  logic ok_q;
  logic [RETRY_W-1:0] retries_q;

  // Level set while power is off, judged after the wait, retried on pulsing
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_q <= H_IDLE;
      ms_q <= '0;
      req_q <= 1'b0;
      req_prev_q <= 1'b0;
      low_seen_q <= 1'b0;
      ok_q <= 1'b0;
      retries_q <= '0;
    end else begin
      req_prev_q <= tune_request;
      if (ms_tick) begin
        ms_q <= ms_q + MS_W'(1);
      end
      case (state_q)
        H_IDLE: begin
          req_q <= tune_request;
          ms_q <= '0;
          state_q <= H_OFF;
        end
        H_OFF: begin
          if (ms_tick && ms_q == MS_W'(POWER_OFF_MS - 1)) begin
            ms_q <= '0;
            state_q <= req_q ? H_WAIT : H_RUN;
          end
        end
        H_WAIT: begin
          low_seen_q <= 1'b0;
          if (ms_tick && ms_q == MS_W'(JUDGE_WAIT_MS - 1)) begin
            ms_q <= '0;
            state_q <= H_JUDGE;
          end
        end
        H_JUDGE: begin
          if (!prog_s) begin
            low_seen_q <= 1'b1;
          end
          if (ms_tick && ms_q == MS_W'(JUDGE_WINDOW_MS - 1)) begin
            ms_q <= '0;
            state_q <= H_OFF;
            if (low_seen_q || !prog_s) begin
              retries_q <= retries_q + RETRY_W'(1);
            end else begin
              ok_q <= 1'b1;
              req_q <= 1'b0;
            end
          end
        end
        H_RUN: begin
          if (tune_request && !req_prev_q) begin
            req_q <= 1'b1;
            ok_q <= 1'b0;
            ms_q <= '0;
            state_q <= H_OFF;
          end
        end
        default: begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Quadrature decoder
  // ==========================================================================
  logic a_prev_q;
  logic b_prev_q;
  logic [POS_W-1:0] pos_q;

  // Count one per single-channel change; A leading counts up
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      a_prev_q <= 1'b0;
      b_prev_q <= 1'b0;
      pos_q <= '0;
    end else begin
      a_prev_q <= a_s;
      b_prev_q <= b_s;
      if (state_q == H_RUN && ((a_s ^ a_prev_q) ^ (b_s ^ b_prev_q))) begin
        if (a_s ^ b_prev_q) begin
          pos_q <= pos_q + POS_W'(1);
        end else begin
          pos_q <= pos_q - POS_W'(1);
        end
      end
    end
  end

  assign link.cal_level = req_q ? CAL_HIGH : CAL_LOW;
  assign power_en = (state_q == H_WAIT) || (state_q == H_JUDGE) || (state_q == H_RUN);
  assign run_active = (state_q == H_RUN);
  assign tune_ok = ok_q;
  assign tune_retries = retries_q;
  assign position = pos_q;

endmodule // eac_host

/* File: verification/eac_link_sva.sv */
// Concurrent checks on the encoder to controller link pins
module eac_link_sva #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic a_p,
  input wire logic a_n,
  input wire logic b_p,
  input wire logic b_n,
  input wire logic i_p,
  input wire logic i_n,
  input wire logic tune_progress_waveform,
  input wire logic emitter_fault_waveform,
  input wire eac_pkg::eac_cal_level_t cal_level
);
  timeunit 1ns;
  timeprecision 1ps;
  import eac_pkg::*;

  // ==========================================================================
  // Helper logic
  // ==========================================================================
  localparam int HALF_CYC = BLINK_HALF_MS * TICK_CYCLES;
  int unsigned tk_q;

  // Cycles since power was applied, for the blink phase
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tk_q <= 0;
    end else begin
      tk_q <= tk_q + 1;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  a_pair_a: assert property (@(posedge clock) disable iff (!rst_n) (a_p || a_n) |-> (a_n == !a_p))
    else $error("channel A twin is not the inverse");
  a_pair_b: assert property (@(posedge clock) disable iff (!rst_n) (b_p || b_n) |-> (b_n == !b_p))
    else $error("channel B twin is not the inverse");
  a_pair_idx: assert property (@(posedge clock) disable iff (!rst_n) (i_p || i_n) |-> (i_n == !i_p))
    else $error("index twin is not the inverse");
  a_one_channel: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(a_p) && $changed(b_p) |-> !a_p && !b_p)
    else $error("A and B changed in the same cycle");
  a_status_excl: assert property (@(posedge clock) disable iff (!rst_n)
    !(tune_progress_waveform && emitter_fault_waveform))
    else $error("progress and fault high together");
  a_blink_edge: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(tune_progress_waveform) && !emitter_fault_waveform
      |-> ((tk_q % HALF_CYC) <= 6) || ((tk_q % HALF_CYC) >= HALF_CYC - 6))
    else $error("progress pulse edge off the half period");
  a_level_settled: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(rst_n) |-> $past(cal_level, 1) == $past(cal_level, 2))
    else $error("request level moved just before power-up");
  a_level_legal: assert property (@(posedge clock) disable iff (!rst_n)
    cal_level inside {CAL_LOW, CAL_HIGH})
    else $error("request level outside low and high");
endmodule // eac_link_sva

/* File: verification/encoder_self_tuning_status_control_tb_top.sv */
// Bench joining encoder and controller with random steps and status scenarios
module encoder_self_tuning_status_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import eac_pkg::*;

  // ==========================================================================
  // Signals
  // ==========================================================================
  localparam int TK = 4;
  localparam int HALF = BLINK_HALF_MS * TK;
  localparam int LIM = 30000;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic step_raw = 1'b0;
  logic dir_raw = 1'b0;
  logic index_raw = 1'b0;
  logic off_scale_raw = 1'b0;
  logic led_high_raw = 1'b0;
  logic tune_done = 1'b0;
  logic tune_request = 1'b0;
  logic outputs_valid;
  eac_dev_state_t dev_state;
  logic power_en;
  logic run_active;
  logic tune_ok;
  logic [RETRY_W-1:0] tune_retries;
  logic [POS_W-1:0] position;
  logic dev_rst_n;
  logic [POS_W-1:0] exp_pos = '0;
  int n_errors = 0;
  int n_checks = 0;
  int seed = 65746;
  int k;
  bit hi;
  bit lo;
  bit other;

  // Clock and controller-gated encoder power
  always #25 clock = ~clock;
  assign dev_rst_n = power_en & rst_n;

  eac_link_if link ();
  eac_device #(.TICK_CYCLES(TK)) i_eac_device (.clock(clock), .rst_n(dev_rst_n), .link(link),
    .step_raw(step_raw), .dir_raw(dir_raw), .index_raw(index_raw), .off_scale_raw(off_scale_raw),
    .led_high_raw(led_high_raw), .tune_done(tune_done), .outputs_valid(outputs_valid), .dev_state(dev_state));
  eac_host #(.TICK_CYCLES(TK)) i_eac_host (.clock(clock), .rst_n(rst_n), .link(link),
    .tune_request(tune_request), .power_en(power_en), .run_active(run_active), .tune_ok(tune_ok),
    .tune_retries(tune_retries), .position(position));
  eac_link_sva #(.TICK_CYCLES(TK)) i_eac_link_sva (.clock(clock), .rst_n(dev_rst_n), .a_p(link.a_p),
    .a_n(link.a_n), .b_p(link.b_p), .b_n(link.b_n), .i_p(link.i_p), .i_n(link.i_n),
    .tune_progress_waveform(link.tune_progress_waveform),
    .emitter_fault_waveform(link.emitter_fault_waveform), .cal_level(link.cal_level));

  // ==========================================================================
  // Tasks and functions
  // ==========================================================================
  function automatic logic [POS_W-1:0] delta(input bit d);
    return d ? 16'h0001 : 16'hffff;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t mismatch: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Bench reset with the request level chosen beforehand
  task automatic power_up(input bit req);
    @(negedge clock);
    rst_n = 1'b0;
    tune_request = req;
    exp_pos = '0;
    cyc(20);
    rst_n = 1'b1;
  endtask

  task automatic wait_pow(input bit lvl);
    for (k = 0; k < LIM && dev_rst_n !== lvl; k++) cyc(1);
    chk(dev_rst_n, lvl);
  endtask

  task automatic wait_run();
    for (k = 0; k < LIM && run_active !== 1'b1; k++) cyc(1);
    chk(run_active, 1'b1);
  endtask

  task automatic step(input bit d);
    dir_raw = d;
    step_raw = 1'b1;
    cyc(4);
    step_raw = 1'b0;
    cyc(8);
    exp_pos = exp_pos + delta(d);
  endtask

  // Watches progress and fault for a span and notes what was seen
  task automatic watch(input int n, input bit prog);
    hi = 0;
    lo = 0;
    other = 0;
    repeat (n) begin
      cyc(1);
      if ((prog ? link.tune_progress_waveform : link.emitter_fault_waveform) === 1'b1) hi = 1;
      else lo = 1;
      if ((prog ? link.emitter_fault_waveform : link.tune_progress_waveform) !== 1'b0) other = 1;
    end
  endtask

  // ==========================================================================
  // Watchdog
  // ==========================================================================
  initial begin
    repeat (80000) @(posedge clock);
    n_errors++;
    end_of_test();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    // Normal power-up, outputs invalid until the timeout
    power_up(1'b0);
    wait_pow(1'b1);
    cyc(2);
    chk(dev_state, ST_NORMAL);
    chk(link.cal_level, CAL_LOW);
    cyc(POR_INVALID_MS * TK - 12);
    chk(outputs_valid, 1'b0);
    chk({link.a_p, link.a_n, link.b_p, link.b_n}, 4'h0);
    cyc(20);
    chk(outputs_valid, 1'b1);
    wait_run();
    // Reversal corner, then random directions
    step(1'b1);
    step(1'b0);
    step(1'b0);
    for (int j = 0; j < 40; j++) step($random(seed));
    cyc(10);
    chk(position, exp_pos);
    chk({link.a_n, link.b_n}, {~link.a_p, ~link.b_p});
    index_raw = 1'b1;
    cyc(8);
    chk({link.i_p, link.i_n}, 2'h2);
    index_raw = 1'b0;
    // High emitter current warning and its self clearing
    led_high_raw = 1'b1;
    cyc(8);
    watch(2 * HALF + 10, 1'b0);
    chk({hi, lo, other}, 3'h6);
    led_high_raw = 1'b0;
    cyc(8);
    chk(link.emitter_fault_waveform, 1'b0);
    // Off-scale then still return starts tuning
    off_scale_raw = 1'b1;
    cyc(8);
    chk({link.tune_progress_waveform, link.emitter_fault_waveform}, 2'h1);
    chk(dev_state, ST_NORMAL);
    off_scale_raw = 1'b0;
    cyc(8);
    chk(dev_state, ST_TUNING);
    watch(2 * HALF + 10, 1'b1);
    chk({hi, lo, other}, 3'h6);
    tune_done = 1'b1;
    cyc(1);
    tune_done = 1'b0;
    cyc(6);
    chk(dev_state, ST_DONE);
    watch(HALF + 10, 1'b1);
    chk({hi, lo, other}, 3'h4);
    step(1'b1);
    chk({link.a_p, link.a_n, link.b_p, link.b_n}, 4'h0);
    // Pin-requested tuning that succeeds
    power_up(1'b1);
    wait_pow(1'b1);
    cyc(2);
    chk(dev_state, ST_TUNING);
    chk(link.cal_level, CAL_HIGH);
    tune_done = 1'b1;
    cyc(1);
    tune_done = 1'b0;
    cyc(6);
    chk(dev_state, ST_DONE);
    // No verdict may be drawn before the five second wait has run out
    cyc(JUDGE_WAIT_MS * TK - 100);
    chk({tune_ok, power_en}, 2'h1);
    wait_run();
    chk({tune_ok, tune_retries}, {1'b1, 4'h0});
    cyc(2);
    chk(dev_state, ST_NORMAL);
    chk(link.cal_level, CAL_LOW);
    step(1'b1);
    chk(outputs_valid, 1'b1);
    cyc(10);
    chk(position, exp_pos);
    // Request raised while running, tuning never settles
    tune_request = 1'b0;
    cyc(2);
    tune_request = 1'b1;
    for (k = 0; k < LIM && tune_retries !== 4'h1; k++) cyc(1);
    chk({tune_ok, tune_retries}, {1'b0, 4'h1});
    wait_pow(1'b0);
    wait_pow(1'b1);
    cyc(2);
    chk(dev_state, ST_TUNING);
    chk(link.cal_level, CAL_HIGH);
    end_of_test();
  end
endmodule // encoder_self_tuning_status_control_tb_top
